// ---- icl_pkg.sv ----
// constants for the interrupt clearing block: offsets, fields and reset values
package icl_pkg;

    // ------------------------------------------------------------
    // bus widths and group count
    // ------------------------------------------------------------
    localparam int ADDR_W = 12;
    localparam int DATA_W = 8;
    localparam int NUM_GRP = 6;

    // ------------------------------------------------------------
    // flag group indices
    // ------------------------------------------------------------
    localparam int GI_SYS_EE = 0;
    localparam int GI_REF_AB = 1;
    localparam int GI_REF_CD = 2;
    localparam int GI_L0_LOCK = 3;
    localparam int GI_L0_STATE = 4;
    localparam int GI_L0_MISC = 5;
    // groups below this index form the common group, the rest digital_loop_0
    localparam int GI_FIRST_LOOP0 = 3;

    // ------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------
    localparam logic [ADDR_W-1:0] OFF_FORCED_FAULT = 12'ha03;
    localparam logic [ADDR_W-1:0] OFF_FREQ_SKIP = 12'ha04;
    localparam logic [ADDR_W-1:0] OFF_GROUP_CLEAR = 12'ha05;
    // clearing offsets, group 0 in the low slice
    localparam logic [NUM_GRP*ADDR_W-1:0] CLR_OFFS =
        {12'ha0b, 12'ha0a, 12'ha09, 12'ha08, 12'ha07, 12'ha06};
    // flag view offsets, group 0 in the low slice
    localparam logic [NUM_GRP*ADDR_W-1:0] MON_OFFS =
        {12'hd0b, 12'hd0a, 12'hd09, 12'hd08, 12'hd07, 12'hd06};
    localparam logic [ADDR_W-1:0] OFF_MON_ALERT = 12'hd05;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int GB_ALL = 0;
    localparam int GB_COMMON = 1;
    localparam int GB_LOOP0 = 2;
    localparam int GB_LOOP1 = 3;
    localparam int GB_LOOP3 = 5;
    localparam int GB_WDOG = 7;
    localparam int B_INPUT_A = 0;
    localparam int B_ALERT = 0;

    // ------------------------------------------------------------
    // implemented bit masks and reset values
    // ------------------------------------------------------------
    localparam logic [DATA_W-1:0] MASK_FULL = 8'hff;
    localparam logic [DATA_W-1:0] MASK_REF = 8'h77;
    localparam logic [NUM_GRP*DATA_W-1:0] GRP_MASKS =
        {MASK_FULL, MASK_FULL, MASK_FULL, MASK_REF, MASK_REF, MASK_FULL};
    localparam logic [DATA_W-1:0] RST_BYTE = 8'h00;
    localparam logic [2:0] RST_LOOP_CLR = 3'h0;
    localparam logic RST_BIT = 1'b0;

endpackage : icl_pkg

// ---- icl_irq_clear.sv ----
// interrupt flag store with write-to-clear control and input a fault qualifier
//
// Strobed register access was chosen for this implementation.
`timescale 1ns/1ps

module icl_irq_clear
    import icl_pkg::*;
(
    input  wire logic              clk_sys,
    input  wire logic              rst_n,
    // register port
    input  wire logic [ADDR_W-1:0] reg_addr,
    input  wire logic [DATA_W-1:0] reg_wdata,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    output logic      [DATA_W-1:0] reg_rdata,
    // event inputs, one cycle high per event, same clock
    input  wire logic [DATA_W-1:0] evt_system_clock_pll_eeprom,
    input  wire logic [DATA_W-1:0] evt_ref_a_b,
    input  wire logic [DATA_W-1:0] evt_ref_c_d,
    input  wire logic [DATA_W-1:0] evt_loop0_lock,
    input  wire logic [DATA_W-1:0] evt_loop0_state,
    input  wire logic [DATA_W-1:0] evt_loop0_misc,
    input  wire logic              evt_watchdog_alert,
    input  wire logic              input_a_freq_fault,
    // flag views
    output logic      [DATA_W-1:0] mon_system_clock_pll_eeprom,
    output logic      [DATA_W-1:0] mon_ref_a_b,
    output logic      [DATA_W-1:0] mon_ref_c_d,
    output logic      [DATA_W-1:0] mon_loop0_lock,
    output logic      [DATA_W-1:0] mon_loop0_state,
    output logic      [DATA_W-1:0] mon_loop0_misc,
    output logic                   mon_watchdog_alert,
    output logic                   irq_request,
    output logic      [2:0]        clear_loop_group,
    output logic                   input_a_faulted
);

    // ------------------------------------------------------------
    // group clear decode
    // ------------------------------------------------------------
    wire grp_wr = reg_wr && (reg_addr == OFF_GROUP_CLEAR);
    wire sweep_all = grp_wr && reg_wdata[GB_ALL];
    wire sweep_common = grp_wr && reg_wdata[GB_COMMON];
    wire sweep_loop0 = grp_wr && reg_wdata[GB_LOOP0];
    wire sweep_wdog = grp_wr && reg_wdata[GB_WDOG];

    // loops 1..3 hold their flags elsewhere; they get a one-cycle clear pulse
    wire [2:0] next_loop_clr =
        {3{grp_wr}} & (reg_wdata[GB_LOOP3:GB_LOOP1] | {3{reg_wdata[GB_ALL]}});

    wire [DATA_W-1:0] evt_w [NUM_GRP];
    logic [DATA_W-1:0] flag [NUM_GRP];
    logic [DATA_W-1:0] clr_q [NUM_GRP];
    wire [DATA_W-1:0] next_flag [NUM_GRP];
    // read terms are or-ed along a chain; every offset selects one term at most
    wire [DATA_W-1:0] rd_acc [NUM_GRP+1];

    assign evt_w[GI_SYS_EE] = evt_system_clock_pll_eeprom;
    assign evt_w[GI_REF_AB] = evt_ref_a_b;
    assign evt_w[GI_REF_CD] = evt_ref_c_d;
    assign evt_w[GI_L0_LOCK] = evt_loop0_lock;
    assign evt_w[GI_L0_STATE] = evt_loop0_state;
    assign evt_w[GI_L0_MISC] = evt_loop0_misc;

    // ------------------------------------------------------------
    // per-group clearing register and flag store
    // ------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < NUM_GRP; g++)
        begin : grp
            localparam logic [DATA_W-1:0] VMASK = GRP_MASKS[g*DATA_W +: DATA_W];
            wire own_hit = reg_wr && (reg_addr == CLR_OFFS[g*ADDR_W +: ADDR_W]);
            // a written zero bit contributes nothing; reserved bits are dropped
            wire [DATA_W-1:0] own_clr = own_hit ? (reg_wdata & VMASK) : RST_BYTE;
            wire sweep = sweep_all || ((g < GI_FIRST_LOOP0) ? sweep_common : sweep_loop0);
            wire [DATA_W-1:0] next_clr = own_clr | ({DATA_W{sweep}} & VMASK);
            // set term last so an event in the clearing cycle survives
            assign next_flag[g] = (flag[g] & ~clr_q[g]) | (evt_w[g] & VMASK);
            wire mon_sel = (reg_addr == MON_OFFS[g*ADDR_W +: ADDR_W]);
            assign rd_acc[g+1] = rd_acc[g] | (mon_sel ? flag[g] : RST_BYTE);

            always_ff @(posedge clk_sys)
            begin
                if (!rst_n)
                begin
                    clr_q[g] <= RST_BYTE;
                    flag[g] <= RST_BYTE;
                end
                else
                begin
                    clr_q[g] <= next_clr;   // one cycle only, then back to zero
                    flag[g] <= next_flag[g];
                end
            end
        end
    endgenerate

    // bit positions of each group follow the flag layout one to one:
    // system_clock_pll/eeprom 7 unlock,6 stable,5 lock,4 cal end,3 cal start,
    // 2 watchdog expiry,1 eeprom fault,0 eeprom done
    // ref a/b: 6..4 b valid/fault cleared/fault, 2..0 same for a
    // ref c/d: 6..4 d, 2..0 c
    // loop0 lock: 7 unclamp,6 clamp,5 slew free,4 slew limit,
    // 3 freq lost,2 freq lock,1 phase lost,0 phase lock
    // loop0 state: 7 switch,6 free run,5 holdover,4 history,
    // 3..0 input d..a activated
    // loop0 misc: 7 phase step,6 demap unclamp,5 demap clamp,
    // 4 dist sync,3 analog unlock,2 analog lock,1 cal end,0 cal start

    assign mon_system_clock_pll_eeprom = flag[GI_SYS_EE];
    assign mon_ref_a_b = flag[GI_REF_AB];
    assign mon_ref_c_d = flag[GI_REF_CD];
    assign mon_loop0_lock = flag[GI_L0_LOCK];
    assign mon_loop0_state = flag[GI_L0_STATE];
    assign mon_loop0_misc = flag[GI_L0_MISC];

    // ------------------------------------------------------------
    // watchdog alert flag
    // ------------------------------------------------------------
    logic alert_clr_q;
    wire next_alert_clr = sweep_wdog || sweep_all;
    wire next_alert = (mon_watchdog_alert && !alert_clr_q) || evt_watchdog_alert;

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            alert_clr_q <= RST_BIT;
            mon_watchdog_alert <= RST_BIT;
            clear_loop_group <= RST_LOOP_CLR;
        end
        else
        begin
            alert_clr_q <= next_alert_clr;
            mon_watchdog_alert <= next_alert;
            clear_loop_group <= next_loop_clr;
        end
    end

    // ------------------------------------------------------------
    // interrupt request
    // ------------------------------------------------------------
    wire any_flag = next_alert
                  || (|next_flag[GI_SYS_EE]) || (|next_flag[GI_REF_AB])
                  || (|next_flag[GI_REF_CD]) || (|next_flag[GI_L0_LOCK])
                  || (|next_flag[GI_L0_STATE]) || (|next_flag[GI_L0_MISC]);

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
            irq_request <= RST_BIT;
        else
            irq_request <= any_flag;
    end

    // ------------------------------------------------------------
    // input a qualifier: forced fault and frequency check skip
    // ------------------------------------------------------------
    logic forced_fault;
    logic freq_skip;
    wire ff_wr = reg_wr && (reg_addr == OFF_FORCED_FAULT);
    wire skip_wr = reg_wr && (reg_addr == OFF_FREQ_SKIP);
    wire next_forced_fault = ff_wr ? reg_wdata[B_INPUT_A] : forced_fault;
    wire next_freq_skip = skip_wr ? reg_wdata[B_INPUT_A] : freq_skip;
    wire next_a_faulted = forced_fault || (!freq_skip && input_a_freq_fault);

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            forced_fault <= RST_BIT;
            freq_skip <= RST_BIT;
            input_a_faulted <= RST_BIT;
        end
        else
        begin
            forced_fault <= next_forced_fault;
            freq_skip <= next_freq_skip;
            input_a_faulted <= next_a_faulted;
        end
    end

    // ------------------------------------------------------------
    // read path; clearing registers and unmapped offsets read zero
    // ------------------------------------------------------------
    wire              ff_sel     = (reg_addr == OFF_FORCED_FAULT);
    wire              skip_sel   = (reg_addr == OFF_FREQ_SKIP);
    wire              alert_sel  = (reg_addr == OFF_MON_ALERT);
    wire [DATA_W-1:0] ff_word    = {{(DATA_W-1){1'b0}}, ff_sel && forced_fault} << B_INPUT_A;
    wire [DATA_W-1:0] skip_word  = {{(DATA_W-1){1'b0}}, skip_sel && freq_skip} << B_INPUT_A;
    wire [DATA_W-1:0] alert_word = {{(DATA_W-1){1'b0}}, alert_sel && mon_watchdog_alert} << B_ALERT;

    assign rd_acc[0] = ff_word | skip_word | alert_word;

    // outside a read strobe the data lines rest at zero
    wire [DATA_W-1:0] next_rdata = reg_rd ? rd_acc[NUM_GRP] : RST_BYTE;

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
            reg_rdata <= RST_BYTE;
        else
            reg_rdata <= next_rdata;
    end

endmodule : icl_irq_clear

// ---- icl_irq_clear_checker.sv ----
// port assertions for the interrupt clearing block
`timescale 1ns/1ps
module icl_irq_clear_checker
    import icl_pkg::*;
(
    input wire logic              clk_sys,
    input wire logic              rst_n,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    input wire logic              reg_wr,
    input wire logic              reg_rd,
    input wire logic [DATA_W-1:0] reg_rdata,
    input wire logic [DATA_W-1:0] evt_system_clock_pll_eeprom,
    input wire logic [DATA_W-1:0] evt_loop0_lock,
    input wire logic [DATA_W-1:0] mon_system_clock_pll_eeprom,
    input wire logic [DATA_W-1:0] mon_ref_a_b,
    input wire logic [DATA_W-1:0] mon_ref_c_d,
    input wire logic [DATA_W-1:0] mon_loop0_lock,
    input wire logic [DATA_W-1:0] mon_loop0_state,
    input wire logic [DATA_W-1:0] mon_loop0_misc,
    input wire logic              mon_watchdog_alert,
    input wire logic              irq_request,
    input wire logic [2:0]        clear_loop_group
);
    default clocking @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);
    AST_RDATA_IDLE: assert property (!reg_rd |=> reg_rdata == 8'h00)
        else $error("read data not zero outside a read");
    AST_CLR_READ_ZERO: assert property (reg_rd && reg_addr inside {[12'ha05:12'ha0b]}
        |=> reg_rdata == 8'h00) else $error("clearing register read not zero");
    AST_GROUP_PULSE: assert property (reg_wr && reg_addr == 12'ha05 |=> clear_loop_group
        == ($past(reg_wdata[0]) ? 3'h7 : $past(reg_wdata[5:3]))) else $error("loop pulse wrong");
    AST_PULSE_ONCE: assert property (!(reg_wr && reg_addr == 12'ha05)
        |=> clear_loop_group == 3'h0) else $error("loop pulse not one cycle");
    AST_SYS_CLEAR: assert property ((reg_wr && reg_addr == 12'ha06) ##1
        (evt_system_clock_pll_eeprom == 8'h00) |=> (mon_system_clock_pll_eeprom & $past(reg_wdata, 2)) == 8'h00)
        else $error("flag not cleared");
    AST_SET_WINS: assert property (evt_loop0_lock != 8'h00 |=>
        (mon_loop0_lock & $past(evt_loop0_lock)) == $past(evt_loop0_lock))
        else $error("event lost");
    AST_IRQ_OR: assert property (irq_request == |{mon_system_clock_pll_eeprom, mon_ref_a_b,
        mon_ref_c_d, mon_loop0_lock, mon_loop0_state, mon_loop0_misc, mon_watchdog_alert})
        else $error("request not the or of flags");
    AST_REF_RSVD: assert property (((mon_ref_a_b | mon_ref_c_d) & 8'h88) == 8'h00)
        else $error("reserved reference flag set");
endmodule : icl_irq_clear_checker
bind icl_irq_clear icl_irq_clear_checker icl_irq_clear_checker_i (.clk_sys, .rst_n, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .evt_system_clock_pll_eeprom, .evt_loop0_lock,
    .mon_system_clock_pll_eeprom, .mon_ref_a_b, .mon_ref_c_d, .mon_loop0_lock, .mon_loop0_state,
    .mon_loop0_misc, .mon_watchdog_alert, .irq_request, .clear_loop_group);

// ---- test_irq_clear_logic.sv ----
// self-checking bench for the interrupt clearing block
`timescale 1ns/1ps
module test_irq_clear_logic;
    import icl_pkg::*;
    logic              clk_sys = 1'b0;
    logic              rst_n = 1'b0;
    logic [ADDR_W-1:0] reg_addr = 12'h000;
    logic [DATA_W-1:0] reg_wdata = 8'h00;
    logic              reg_wr = 1'b0;
    logic              reg_rd = 1'b0;
    logic [DATA_W-1:0] reg_rdata;
    logic [DATA_W-1:0] evt [NUM_GRP] = '{default: 8'h00};
    logic [DATA_W-1:0] mon [NUM_GRP];
    logic [DATA_W-1:0] flg [NUM_GRP] = '{default: 8'h00};
    logic              evt_watchdog_alert = 1'b0;
    logic              input_a_freq_fault = 1'b0;
    logic              mon_watchdog_alert, irq_request, input_a_faulted, alrt = 1'b0;
    logic [2:0]        clear_loop_group;
    logic [7:0]        pats [6] = '{8'h02, 8'h04, 8'h80, 8'h01, 8'h38, 8'h40};
    logic [31:0]       seed = 32'h0000004c;
    int                fail_count = 0;
    int                n_tests = 0;
    always #2.5 clk_sys = ~clk_sys;
    icl_irq_clear icl_irq_clear_i (.clk_sys, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .reg_rdata, .evt_system_clock_pll_eeprom(evt[0]), .evt_ref_a_b(evt[1]), .evt_ref_c_d(evt[2]),
        .evt_loop0_lock(evt[3]), .evt_loop0_state(evt[4]), .evt_loop0_misc(evt[5]),
        .evt_watchdog_alert, .input_a_freq_fault, .mon_system_clock_pll_eeprom(mon[0]),
        .mon_ref_a_b(mon[1]), .mon_ref_c_d(mon[2]), .mon_loop0_lock(mon[3]),
        .mon_loop0_state(mon[4]), .mon_loop0_misc(mon[5]), .mon_watchdog_alert,
        .irq_request, .clear_loop_group, .input_a_faulted);
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [7:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[7:0];
    endfunction : xs
    function automatic logic [7:0] exp_pulse(input logic [7:0] p);
        return {5'h00, p[GB_ALL] ? 3'h7 : p[GB_LOOP3:GB_LOOP1]};
    endfunction : exp_pulse
    function automatic logic [7:0] exp_faulted(input logic frc, input logic skp, input logic flt);
        return {7'h00, frc | (!skp & flt)};
    endfunction : exp_faulted
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("CHECK FAILED at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask : check
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [11:0] a, input logic [7:0] exp);
        @(posedge clk_sys);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1 check(reg_rdata, exp);
    endtask : rd
    task automatic chk_all();
        logic pend;
        pend = alrt;
        for (int g = 0; g < NUM_GRP; g++)
        begin
            check(mon[g], flg[g]);
            pend |= |flg[g];
        end
        check({7'h00, mon_watchdog_alert}, {7'h00, alrt});
        check({7'h00, irq_request}, {7'h00, pend});
    endtask : chk_all
    task automatic raise();
        logic [7:0] r;
        @(posedge clk_sys);
        for (int g = 0; g < NUM_GRP; g++)
        begin
            r = xs();
            evt[g] <= r;
            flg[g] |= r & GRP_MASKS[g*8+:8];
        end
        evt_watchdog_alert <= 1'b1;
        alrt = 1'b1;
        @(posedge clk_sys);
        foreach (evt[g]) evt[g] <= 8'h00;
        evt_watchdog_alert <= 1'b0;
    endtask : raise
    // an event e may arrive in the cycle the clear takes effect
    task automatic clr(input int g, input logic [7:0] c, input logic [7:0] e);
        wr(CLR_OFFS[g*12+:12], c);
        evt[g] <= e;
        @(posedge clk_sys);
        evt[g] <= 8'h00;
        flg[g] = (flg[g] & ~c) | (e & GRP_MASKS[g*8+:8]);
        #1 chk_all();
    endtask : clr
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : report_and_stop
    initial
    begin
        repeat (5000) @(posedge clk_sys);
        fail_count++;
        report_and_stop();
    end
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    initial
    begin
        repeat (12) @(posedge clk_sys);
        rst_n <= 1'b1;
        @(posedge clk_sys);
        #1 chk_all();
        check({7'h00, input_a_faulted}, 8'h00);
        rd(OFF_FREQ_SKIP, 8'h00);
        rd(OFF_FORCED_FAULT, 8'h00);
        repeat (5)
        begin
            raise();
            for (int g = 0; g < NUM_GRP; g++)
            begin
                rd(MON_OFFS[g*12+:12], flg[g]);
                clr(g, xs(), xs() & 8'h11);
            end
        end
        clr(0, 8'h04, 8'h04);
        clr(0, 8'h00, 8'h00);
        clr(3, 8'hff, 8'h00);
        for (int a = 12'ha05; a <= 12'ha0b; a++) rd(a[11:0], 8'h00);
        rd(12'h123, 8'h00);
        foreach (pats[i])
        begin
            raise();
            wr(OFF_GROUP_CLEAR, pats[i]);
            #1 check({5'h00, clear_loop_group}, exp_pulse(pats[i]));
            for (int g = 0; g < NUM_GRP; g++)
                if (pats[i][0] | (g < GI_FIRST_LOOP0 ? pats[i][1] : pats[i][2])) flg[g] = 8'h00;
            if (pats[i][0] | pats[i][7]) alrt = 1'b0;
            @(posedge clk_sys);
            #1 chk_all();
            rd(OFF_MON_ALERT, {7'h00, alrt});
        end
        for (int k = 0; k < 8; k++)
        begin
            wr(OFF_FORCED_FAULT, {7'h00, k[0]});
            wr(OFF_FREQ_SKIP, {7'h00, k[1]});
            input_a_freq_fault <= k[2];
            repeat (2) @(posedge clk_sys);
            #1 check({7'h00, input_a_faulted}, exp_faulted(k[0], k[1], k[2]));
        end
        rd(OFF_FREQ_SKIP, 8'h01);
        rd(OFF_FORCED_FAULT, 8'h01);
        // mid-run reset with flags, skip and forced fault all set
        raise();
        @(posedge clk_sys);
        rst_n <= 1'b0;
        input_a_freq_fault <= 1'b0;
        repeat (2) @(posedge clk_sys);
        rst_n <= 1'b1;
        foreach (flg[g]) flg[g] = 8'h00;
        alrt = 1'b0;
        @(posedge clk_sys);
        #1 chk_all();
        check({7'h00, input_a_faulted}, 8'h00);
        rd(OFF_FREQ_SKIP, 8'h00);
        rd(OFF_FORCED_FAULT, 8'h00);
        report_and_stop();
    end
endmodule : test_irq_clear_logic
